// [hdl/dfs_pkg.sv]
// Functional notes
// - Sync-lost flag, bit 7 of sync status, sets when lock is lost.
// - Sync-locked flag, bit 6 of sync status, shows lock attained.
// - Averaged sync phase reads as unsigned 6.2 value, 0.25 per code.
// - Status bits 5/4 flag frame lines above 1.7 V / below 0.7 V.
// - Status bits 3/2 flag strobe lines above upper / below lower level.
// - Status bits 1/0 flag data lines above upper / below lower level.
// - Revision 2 only: 2-bit strobe delay 350/590/800/925 ps, reset 00.
// - FIFO reset puts write pointer ahead by 3-bit offset, reset 100.
// - Acknowledge bit 2 sets once pointers are realigned.
// - FIFO fill level reads as 8-bit thermometer code.
// - Sync phase request, in converter clock cycles, positions output after sync.
package dfs_pkg;

    // Register offsets on the serial port
    localparam logic [6:0] ADDR_SYNC_PHASE_REQ = 7'h11;
    localparam logic [6:0] ADDR_SYNC_LOCK_STATE = 7'h12;
    localparam logic [6:0] ADDR_SYNC_PHASE_MEAS = 7'h13;
    localparam logic [6:0] ADDR_INPUT_LEVEL_FLAGS = 7'h15;
    localparam logic [6:0] ADDR_STROBE_DELAY_SELECT = 7'h16;
    localparam logic [6:0] ADDR_FIFO_POINTER_OFFSET = 7'h17;
    localparam logic [6:0] ADDR_FIFO_STATE_FLAGS = 7'h18;
    localparam logic [6:0] ADDR_FIFO_FILL_LEVEL = 7'h19;

    // Field positions
    localparam int BIT_SYNC_LOST = 7;
    localparam int BIT_SYNC_LOCKED = 6;
    localparam int BIT_FIFO_WARN1 = 7;
    localparam int BIT_FIFO_WARN2 = 6;
    localparam int BIT_ALIGN_ACK = 2;
    localparam int BIT_ALIGN_REQ = 1;

    // Reset values
    localparam logic [1:0] STROBE_DELAY_RST = 2'h0;
    localparam logic [2:0] PTR_OFFSET_RST = 3'h4;
    localparam logic [5:0] SYNC_PHASE_REQ_RST = 6'h00;

    // Silicon revision that carries the strobe delay
    localparam int STROBE_DELAY_REV = 2;

    // Serial frame: read flag and address, then one data byte
    localparam logic [3:0] SPI_LAST_BIT = 4'h7;

    typedef enum logic [1:0] {
        SPI_IDLE,
        SPI_INSTR,
        SPI_DATA,
        SPI_DONE
    } dfs_spi_e;

endpackage : dfs_pkg

// [hdl/dfs_input_status.sv]
`timescale 1ns/1ns
module dfs_input_status #(
    parameter int DATA_W = 16,     // Parallel data lines
    parameter int FIFO_AW = 3,     // FIFO address bits, depth 2**FIFO_AW
    parameter int SILICON_REV = 2  // Silicon revision of this build
) (
    input wire logic clk_i,                            // Converter clock
    input wire logic arst_n_i,                         // Async reset, active low
    input wire logic data_strobe_input_i,              // Link clock from host
    input wire logic [DATA_W-1:0] parallel_data_inputs_i, // Link data
    input wire logic frame_i,                          // Link frame
    input wire logic [1:0] frame_hi_i,                 // Frame line over upper level
    input wire logic [1:0] frame_lo_i,                 // Frame line under lower level
    input wire logic [1:0] strobe_hi_i,                // Strobe line over upper level
    input wire logic [1:0] strobe_lo_i,                // Strobe line under lower level
    input wire logic [DATA_W-1:0] data_hi_i,           // Data line over upper level
    input wire logic [DATA_W-1:0] data_lo_i,           // Data line under lower level
    input wire logic sync_locked_i,                    // Lock level from sync engine
    input wire logic [7:0] sync_phase_i,               // Averaged phase, 6.2
    input wire logic sync_phase_vld_i,                 // Phase sample valid
    input wire logic spi_csb_n_i,                      // Serial chip select
    input wire logic spi_sclk_i,                       // Serial clock
    input wire logic spi_sdi_i,                        // Serial data in
    output logic spi_sdo_o,                            // Serial data out
    output logic spi_sdo_oe_o,                         // Serial out enable
    output logic [DATA_W-1:0] rd_data_o,               // FIFO output data
    output logic rd_frame_o,                           // FIFO output frame
    output logic rd_valid_o,                           // FIFO output valid
    output logic [1:0] strobe_delay_code_o,            // Strobe delay code
    output logic [5:0] sync_phase_req_o                // Requested sync phase
);
    import dfs_pkg::*;

    localparam int DEPTH = 1 << FIFO_AW;
    localparam int WW = DATA_W + 1;
    localparam int LV_W = 2 * (4 + DATA_W);

    typedef logic [FIFO_AW:0] dfs_ptr_t;

    // Link side state: storage, write pointer, handshake
    typedef struct packed {
        logic [DEPTH-1:0][WW-1:0] mem;
        dfs_ptr_t wr_bin;
        dfs_ptr_t wr_gray;
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic ack_pend;
        logic ack_tgl;
    } dfs_lnk_s;

    // Converter side state
    typedef struct packed {
        dfs_ptr_t wg_s1;
        dfs_ptr_t wg_s2;
        logic ack_s1;
        logic ack_s2;
        logic ack_seen;
        logic [LV_W-1:0] lv_s1;
        logic [LV_W-1:0] lv_s2;
        logic csb_s1;
        logic csb_s2;
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_s3;
        logic sdi_s1;
        logic sdi_s2;
        dfs_ptr_t rd_bin;
        logic req_tgl;
        logic [2:0] offset_snap;
        logic aligning;
        logic [5:0] phase_req;
        logic locked;
        logic lost;
        logic [7:0] phase;
        logic [5:0] lvl;
        logic [1:0] dly;
        logic [2:0] offset;
        logic warn1;
        logic warn2;
        logic ack;
        logic req;
        logic [DEPTH-1:0] fill;
        logic [DATA_W-1:0] rd_data;
        logic rd_frame;
        logic rd_valid;
        dfs_spi_e st;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic rnw;
        logic [6:0] addr;
        logic sdo;
        logic sdo_oe;
    } dfs_core_s;

    dfs_lnk_s l_r;
    dfs_lnk_s l_nxt;
    dfs_core_s c_r;
    dfs_core_s c_nxt;

    // Binary to gray
    function automatic dfs_ptr_t bin2gray(input dfs_ptr_t b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    // Gray to binary
    function automatic dfs_ptr_t gray2bin(input dfs_ptr_t g);
        dfs_ptr_t b;
        b = g;
        for (int i = FIFO_AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray2bin

    // Thermometer code of a count
    function automatic logic [DEPTH-1:0] thermo(input dfs_ptr_t n);
        logic [DEPTH-1:0] t;
        t = '0;
        for (int i = 0; i < DEPTH; i++) begin
            t[i] = (n > dfs_ptr_t'(i));
        end
        return t;
    endfunction : thermo

    // Link domain: write every rising strobe edge except an alignment edge, which reloads instead
    always_comb begin
        l_nxt = l_r;
        l_nxt.req_s1 = c_r.req_tgl;
        l_nxt.req_s2 = l_r.req_s1;
        if (l_r.ack_pend) begin
            l_nxt.ack_pend = 1'b0;
            l_nxt.ack_tgl = ~l_r.ack_tgl;
        end
        if (l_r.req_s2 != l_r.req_seen) begin
            // write pointer ahead
            // Offset snapshot is held steady by the core while the request is open
            l_nxt.wr_bin = dfs_ptr_t'(c_r.offset_snap);
            l_nxt.req_seen = l_r.req_s2;
            l_nxt.ack_pend = 1'b1;
        end else begin
            l_nxt.mem[l_r.wr_bin[FIFO_AW-1:0]] = {frame_i, parallel_data_inputs_i};
            l_nxt.wr_bin = l_r.wr_bin + dfs_ptr_t'(1);
        end
        l_nxt.wr_gray = bin2gray(l_nxt.wr_bin);
    end

    // Link domain register
    always_ff @(posedge data_strobe_input_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    dfs_ptr_t wr_bin_c;
    dfs_ptr_t diff_c;
    logic [FIFO_AW-1:0] dlow_c;
    logic rise_c;
    logic fall_c;
    logic [7:0] nsh_c;
    logic [7:0] rd_val_c;

    // Pointer distance and serial edges
    always_comb begin
        wr_bin_c = gray2bin(c_r.wg_s2);
        diff_c = wr_bin_c - c_r.rd_bin;
        dlow_c = diff_c[FIFO_AW-1:0];
        rise_c = c_r.sclk_s2 & ~c_r.sclk_s3;
        fall_c = ~c_r.sclk_s2 & c_r.sclk_s3;
        nsh_c = {c_r.shift[6:0], c_r.sdi_s2};
    end

    // Register read multiplexer
    always_comb begin
        rd_val_c = 8'h00;
        case (nsh_c[6:0])
            ADDR_SYNC_PHASE_REQ: rd_val_c = {2'h0, c_r.phase_req};
            ADDR_SYNC_LOCK_STATE: begin
                rd_val_c[BIT_SYNC_LOST] = c_r.lost;
                rd_val_c[BIT_SYNC_LOCKED] = c_r.locked;
            end
            ADDR_SYNC_PHASE_MEAS: rd_val_c = c_r.phase;
            ADDR_INPUT_LEVEL_FLAGS: rd_val_c = {2'h0, c_r.lvl};
            ADDR_STROBE_DELAY_SELECT: rd_val_c = {6'h00, c_r.dly};
            ADDR_FIFO_POINTER_OFFSET: rd_val_c = {5'h00, c_r.offset};
            ADDR_FIFO_STATE_FLAGS: begin
                rd_val_c[BIT_FIFO_WARN1] = c_r.warn1;
                rd_val_c[BIT_FIFO_WARN2] = c_r.warn2;
                rd_val_c[BIT_ALIGN_ACK] = c_r.ack;
                rd_val_c[BIT_ALIGN_REQ] = c_r.req;
            end
            ADDR_FIFO_FILL_LEVEL: rd_val_c = 8'(c_r.fill);
            default: rd_val_c = 8'h00;
        endcase
    end

    // Converter domain next state
    always_comb begin
        c_nxt = c_r;
        // Synchronisers for pointer, handshake, comparators and serial pins
        c_nxt.wg_s1 = l_r.wr_gray;
        c_nxt.wg_s2 = c_r.wg_s1;
        c_nxt.ack_s1 = l_r.ack_tgl;
        c_nxt.ack_s2 = c_r.ack_s1;
        c_nxt.lv_s1 = {data_lo_i, data_hi_i, strobe_lo_i, strobe_hi_i, frame_lo_i, frame_hi_i};
        c_nxt.lv_s2 = c_r.lv_s1;
        c_nxt.csb_s1 = spi_csb_n_i;
        c_nxt.csb_s2 = c_r.csb_s1;
        c_nxt.sclk_s1 = spi_sclk_i;
        c_nxt.sclk_s2 = c_r.sclk_s1;
        c_nxt.sclk_s3 = c_r.sclk_s2;
        c_nxt.sdi_s1 = spi_sdi_i;
        c_nxt.sdi_s2 = c_r.sdi_s1;

        c_nxt.locked = sync_locked_i;
        if (c_r.locked && !sync_locked_i) begin
            c_nxt.lost = 1'b1;
        end else if (sync_locked_i) begin
            c_nxt.lost = 1'b0;
        end
        if (sync_phase_vld_i) begin
            c_nxt.phase = sync_phase_i;
        end

        c_nxt.lvl[5] = |c_r.lv_s2[1:0];
        c_nxt.lvl[4] = |c_r.lv_s2[3:2];
        c_nxt.lvl[3] = |c_r.lv_s2[5:4];
        c_nxt.lvl[2] = |c_r.lv_s2[7:6];
        c_nxt.lvl[1] = |c_r.lv_s2[8+DATA_W-1:8];
        c_nxt.lvl[0] = |c_r.lv_s2[LV_W-1:8+DATA_W];

        c_nxt.warn1 = (dlow_c <= FIFO_AW'(1)) || (dlow_c >= FIFO_AW'(DEPTH - 1));
        c_nxt.warn2 = (dlow_c <= FIFO_AW'(2)) || (dlow_c >= FIFO_AW'(DEPTH - 2));
        c_nxt.fill = thermo(diff_c);

        // Drain one entry per clock while not empty and not aligning
        c_nxt.rd_valid = 1'b0;
        if (!c_r.aligning && diff_c != '0) begin
            {c_nxt.rd_frame, c_nxt.rd_data} = l_r.mem[c_r.rd_bin[FIFO_AW-1:0]];
            c_nxt.rd_valid = 1'b1;
            c_nxt.rd_bin = c_r.rd_bin + dfs_ptr_t'(1);
        end

        // Serial port
        if (c_r.csb_s2) begin
            c_nxt.st = SPI_IDLE;
            c_nxt.sdo_oe = 1'b0;
            c_nxt.cnt = 4'h0;
        end else begin
            case (c_r.st)
                SPI_IDLE: begin
                    c_nxt.st = SPI_INSTR;
                    c_nxt.cnt = 4'h0;
                end
                SPI_INSTR: begin
                    if (rise_c) begin
                        c_nxt.shift = nsh_c;
                        c_nxt.cnt = c_r.cnt + 4'h1;
                        if (c_r.cnt == SPI_LAST_BIT) begin
                            c_nxt.rnw = nsh_c[7];
                            c_nxt.addr = nsh_c[6:0];
                            c_nxt.cnt = 4'h0;
                            c_nxt.st = SPI_DATA;
                            if (nsh_c[7]) begin
                                c_nxt.shift = rd_val_c;
                            end
                        end
                    end
                end
                SPI_DATA: begin
                    if (fall_c && c_r.rnw) begin
                        c_nxt.sdo = c_r.shift[7];
                        c_nxt.sdo_oe = 1'b1;
                        c_nxt.shift = {c_r.shift[6:0], 1'b0};
                    end
                    if (rise_c) begin
                        c_nxt.cnt = c_r.cnt + 4'h1;
                        if (!c_r.rnw) begin
                            c_nxt.shift = nsh_c;
                        end
                        if (c_r.cnt == SPI_LAST_BIT) begin
                            c_nxt.st = SPI_DONE;
                            if (!c_r.rnw) begin
                                case (c_r.addr)
                                    ADDR_SYNC_PHASE_REQ: c_nxt.phase_req = nsh_c[5:0];
                                    ADDR_STROBE_DELAY_SELECT: begin
                                        if (SILICON_REV == STROBE_DELAY_REV) begin
                                            c_nxt.dly = nsh_c[1:0];
                                        end
                                    end
                                    ADDR_FIFO_POINTER_OFFSET: c_nxt.offset = nsh_c[2:0];
                                    ADDR_FIFO_STATE_FLAGS: begin
                                        if (nsh_c[BIT_ALIGN_REQ]) begin
                                            c_nxt.req = 1'b1;
                                            c_nxt.ack = 1'b0;
                                            c_nxt.aligning = 1'b1;
                                            c_nxt.rd_bin = '0;
                                            c_nxt.offset_snap = c_r.offset;
                                            c_nxt.req_tgl = ~c_r.req_tgl;
                                        end
                                    end
                                    default: c_nxt.req = c_nxt.req;
                                endcase
                            end
                        end
                    end
                end
                SPI_DONE: c_nxt.st = SPI_DONE;
                default: c_nxt.st = SPI_IDLE;
            endcase
        end

        if (c_r.ack_s2 != c_r.ack_seen) begin
            c_nxt.ack_seen = c_r.ack_s2;
            c_nxt.ack = 1'b1;
            c_nxt.req = 1'b0;
            c_nxt.aligning = 1'b0;
        end
    end

    // Converter domain register
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            c_r <= '0;
            c_r.csb_s1 <= 1'b1;
            c_r.csb_s2 <= 1'b1;
            c_r.st <= SPI_IDLE;
            c_r.phase_req <= SYNC_PHASE_REQ_RST;
            c_r.dly <= STROBE_DELAY_RST;
            c_r.offset <= PTR_OFFSET_RST;
            c_r.offset_snap <= PTR_OFFSET_RST;
        end else begin
            c_r <= c_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign spi_sdo_o = c_r.sdo;
    assign spi_sdo_oe_o = c_r.sdo_oe;
    assign rd_data_o = c_r.rd_data;
    assign rd_frame_o = c_r.rd_frame;
    assign rd_valid_o = c_r.rd_valid;
    assign strobe_delay_code_o = c_r.dly;
    assign sync_phase_req_o = c_r.phase_req;

endmodule : dfs_input_status

// [test/dfs_input_status_chk.sv]
`timescale 1ns/1ns
// Port-level checks on the status block
module dfs_input_status_chk (
    input wire logic clk_i, // Converter clock
    input wire logic arst_n_i, // Async reset
    input wire logic spi_csb_n_i, // Serial select
    input wire logic spi_sclk_i, // Serial clock
    input wire logic spi_sdo_o, // Serial out
    input wire logic spi_sdo_oe_o, // Serial out enable
    input wire logic rd_valid_o, // FIFO valid
    input wire logic [1:0] strobe_delay_code_o, // Delay code
    input wire logic [5:0] sync_phase_req_o // Phase request
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // Outputs leave reset at their idle values
    AST_STROBE_RST: assert property ($rose(arst_n_i) |-> strobe_delay_code_o == 2'h0)
        else $error("strobe delay code not 00 after reset");
    AST_RST_OUTS: assert property ($rose(arst_n_i) |-> (!rd_valid_o && !spi_sdo_oe_o
        && sync_phase_req_o == 6'h00)[*2])
        else $error("outputs not idle after reset");
    // Control fields move only through a serial write
    AST_STROBE_HOLD: assert property (spi_csb_n_i[*6] |=> $stable(strobe_delay_code_o))
        else $error("strobe delay code moved while port idle");
    AST_PHASE_HOLD: assert property (spi_csb_n_i[*6] |=> $stable(sync_phase_req_o))
        else $error("phase request moved while port idle");
    AST_STROBE_WHEN: assert property ($changed(strobe_delay_code_o)
        |-> $past(spi_csb_n_i, 3) == 1'b0)
        else $error("strobe delay code changed outside a frame");
    // Read-back driver is released between frames
    AST_OE_IDLE: assert property (spi_csb_n_i[*6] |-> !spi_sdo_oe_o)
        else $error("serial out driven while deselected");
    AST_OE_LATE: assert property ($fell(spi_csb_n_i) |-> (!spi_sdo_oe_o)[*8])
        else $error("serial out driven during instruction");
    AST_SDO_HOLD: assert property ((!spi_csb_n_i && spi_sclk_i)[*8] ##0 spi_sdo_oe_o
        |=> $stable(spi_sdo_o))
        else $error("serial out moved without a clock fall");
endmodule : dfs_input_status_chk

bind dfs_input_status dfs_input_status_chk u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .spi_csb_n_i(spi_csb_n_i), .spi_sclk_i(spi_sclk_i), .spi_sdo_o(spi_sdo_o),
    .spi_sdo_oe_o(spi_sdo_oe_o), .rd_valid_o(rd_valid_o),
    .strobe_delay_code_o(strobe_delay_code_o), .sync_phase_req_o(sync_phase_req_o));

// [test/dfs_link_host.sv]
`timescale 1ns/1ns
// Host side of the link: gated strobe and counting data
module dfs_link_host (
    input wire logic run_i, // Strobe runs while high
    output logic strobe_o, // Data strobe
    output logic [15:0] data_o, // Parallel data
    output logic frame_o // Frame bit, equals data bit 0
);
    // Strobe of 32 ns, phase unrelated to the converter clock; parks low on stall
    initial begin
        strobe_o = 1'b0;
        #7;
        forever begin
            #16;
            if (run_i || strobe_o) begin
                strobe_o = ~strobe_o;
            end
        end
    end
    // New word launched half a period before its capture edge
    initial begin
        data_o = 16'h0000;
        frame_o = 1'b0;
    end
    always @(negedge strobe_o) begin
        data_o <= data_o + 16'h0001;
        frame_o <= ~data_o[0];
    end
endmodule : dfs_link_host

// [test/test_dfs_input_status.sv]
`timescale 1ns/1ns
// Self-checking bench for the input status registers
module test_dfs_input_status;
    import dfs_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic run = 1'b1;
    logic strobe, frame, sdo, sdo_oe, rd_frame, rd_valid;
    logic [15:0] pdata, rd_data;
    logic [1:0] fhi = 2'h0, flo = 2'h0, shi = 2'h0, slo = 2'h0, dly;
    logic [15:0] dhi = 16'h0000, dlo = 16'h0000;
    logic lock = 1'b0, phase_vld = 1'b0, csb_n = 1'b1, sclk = 1'b0, sdi = 1'b0;
    logic [7:0] phase = 8'h00;
    logic [5:0] preq;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;

    // Clock and hang guard
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            final_report();
        end
    end

    dfs_link_host u_host (.run_i(run), .strobe_o(strobe), .data_o(pdata), .frame_o(frame));
    dfs_input_status #(.DATA_W(16), .FIFO_AW(3), .SILICON_REV(2)) dut (.clk_i(clk),
        .arst_n_i(arst_n), .data_strobe_input_i(strobe), .parallel_data_inputs_i(pdata),
        .frame_i(frame), .frame_hi_i(fhi), .frame_lo_i(flo), .strobe_hi_i(shi),
        .strobe_lo_i(slo), .data_hi_i(dhi), .data_lo_i(dlo), .sync_locked_i(lock),
        .sync_phase_i(phase), .sync_phase_vld_i(phase_vld), .spi_csb_n_i(csb_n),
        .spi_sclk_i(sclk), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
        .rd_data_o(rd_data), .rd_frame_o(rd_frame), .rd_valid_o(rd_valid),
        .strobe_delay_code_o(dly), .sync_phase_req_o(preq));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One 16-bit serial frame, half period of 8 clocks, read bits taken before each rise
    task automatic spi(input logic rd, input logic [6:0] a, input logic [7:0] wd,
                       output logic [7:0] rdat);
        logic [15:0] word;
        word = {rd, a, wd};
        rdat = 8'h00;
        @(negedge clk);
        csb_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(negedge clk);
            sdi = word[i];
            repeat (7) @(negedge clk);
            // Released output reads as the inverse so a missing enable shows up
            if (i < 8) rdat[i] = sdo_oe ? sdo : ~sdo;
            sclk = 1'b1;
            repeat (8) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (8) @(negedge clk);
        csb_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask : spi

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        spi(1'b0, a, d, x);
    endtask : wr

    task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        spi(1'b1, a, 8'h00, d);
        chk({8'h00, d}, {8'h00, e});
    endtask : rdchk

    task automatic t_reset;
        rdchk(ADDR_STROBE_DELAY_SELECT, 8'h00);
        rdchk(ADDR_FIFO_POINTER_OFFSET, 8'h04);
        rdchk(ADDR_SYNC_PHASE_REQ, 8'h00);
        rdchk(7'h1a, 8'h00);
    endtask : t_reset

    // Every delay code, phase request masking, offset top value
    task automatic t_regs;
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_STROBE_DELAY_SELECT, 8'(c));
            rdchk(ADDR_STROBE_DELAY_SELECT, 8'(c));
            chk({14'h0000, dly}, 16'(c));
        end
        wr(ADDR_SYNC_PHASE_REQ, 8'hea);
        rdchk(ADDR_SYNC_PHASE_REQ, 8'h2a);
        chk({10'h000, preq}, 16'h002a);
        wr(ADDR_FIFO_POINTER_OFFSET, 8'h07);
        rdchk(ADDR_FIFO_POINTER_OFFSET, 8'h07);
        wr(ADDR_FIFO_POINTER_OFFSET, 8'h04);
    endtask : t_regs

    // Lock, loss, relock; phase readback against the request
    task automatic t_sync;
        logic [7:0] d;
        lock = 1'b1;
        rdchk(ADDR_SYNC_LOCK_STATE, 8'h40);
        lock = 1'b0;
        rdchk(ADDR_SYNC_LOCK_STATE, 8'h80);
        lock = 1'b1;
        rdchk(ADDR_SYNC_LOCK_STATE, 8'h40);
        for (int k = 0; k < 2; k++) begin
            phase = (k == 0) ? 8'ha8 : 8'hff;
            phase_vld = 1'b1;
            @(negedge clk);
            phase_vld = 1'b0;
            spi(1'b1, ADDR_SYNC_PHASE_MEAS, 8'h00, d);
            chk({8'h00, d}, {8'h00, phase});
            chk(16'(d[7:2] == preq), 16'(k == 0));
        end
    endtask : t_sync

    // One comparator at a time, each flag in its own bit
    task automatic t_levels;
        for (int b = 0; b < 7; b++) begin
            fhi = {1'b0, b == 5};
            flo = {b == 4, 1'b0};
            shi = {b == 3, 1'b0};
            slo = {1'b0, b == 2};
            dhi = 16'(b == 1) << 9;
            dlo = 16'(b == 0) << 15;
            repeat (5) @(negedge clk);
            rdchk(ADDR_INPUT_LEVEL_FLAGS, 8'(8'h01 << b) & 8'h3f);
        end
    endtask : t_levels

    // Soft alignment: request, acknowledge, self-clear, thermometer fill
    task automatic t_align;
        logic [7:0] d;
        wr(ADDR_FIFO_STATE_FLAGS, 8'h02);
        repeat (40) @(negedge clk);
        spi(1'b1, ADDR_FIFO_STATE_FLAGS, 8'h00, d);
        chk({15'h0000, d[2]}, 16'h0001);
        chk({15'h0000, d[1]}, 16'h0000);
        // Reader outruns the host, so the pointers sit within one entry
        chk({14'h0000, d[7:6]}, 16'h0003);
        spi(1'b1, ADDR_FIFO_FILL_LEVEL, 8'h00, d);
        chk({8'h00, d & (d + 8'h01)}, 16'h0000);
    endtask : t_align

    // Words come out in order with their frame bit, across a host stall
    task automatic t_link;
        logic [15:0] prev;
        int seen;
        seen = 0;
        prev = 16'h0000;
        for (int t = 0; t < 400; t++) begin
            @(negedge clk);
            run = !(t >= 150 && t < 200);
            if (rd_valid === 1'b1) begin
                if (seen > 0) chk(rd_data, prev + 16'h0001);
                chk({15'h0000, rd_frame}, {15'h0000, rd_data[0]});
                prev = rd_data;
                seen++;
            end
        end
        chk(16'(seen > 100), 16'h0001);
    endtask : t_link

    task automatic final_report;
        $display("Checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    // Main sequence
    initial begin
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        repeat (8) @(negedge clk);
        t_reset();
        t_regs();
        t_sync();
        t_levels();
        t_align();
        t_link();
        final_report();
    end
endmodule : test_dfs_input_status
